// ===== hdl/supply_monitor_power_switch.sv
`timescale 1ns/1ps
// How it works
// - oscillator-stop flag sets after 10 ms without oscillation; sticky, write 0 clears it once oscillation resumes
// - oscillator, main, battery and compensation flags leave as event sources
// - invalid-time flag sets whenever power-on-reset or oscillator-stop flag sets
// - main and battery drop flags only act with automatic switching enabled
// - main-drop flag sticky; write 0 clears only with main above rise level
// - battery-drop flag needs two low checks in a row; cleared above rise level
// - compensation-stop flag sets at low internal voltage; sticky, write 0 clears it once voltage recovers
// - compensation updates halt and last correction is held while voltage low
// - in Normal with automatic switching, main drop enters Backup mode
// - Backup mode opens switch one, isolating main supply from battery
// - Backup mode ignores host inputs and floats data and clock outputs
// - in Backup, timekeeping runs as in Normal while battery is high enough
// - main supply recovery in Backup returns operation to Normal mode
// - with automatic switching, charge enable charges battery in Normal while main exceeds battery
// - automatic switching overrides the manual switch select field
// - reset loads switching off, charging off, manual select 0b01
// - Backup samples main rise comparator every 31.25 ms
// - battery compared every 3 s when detection enabled, no supply switch
module supply_monitor_power_switch #(
  parameter int unsigned OSC_CYC = supply_pkg::OSC_STOP_CYC,
  parameter int unsigned SMP_CYC = supply_pkg::MAIN_SAMPLE_CYC,
  parameter int unsigned BAT_CYC = supply_pkg::BAT_CHECK_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        osc_active,
  input  wire logic        main_below_drop,
  input  wire logic        main_above_rise,
  input  wire logic        battery_below_drop,
  input  wire logic        battery_above_rise,
  input  wire logic        vout_below_comp,
  input  wire logic        main_above_battery,
  input  wire logic        battery_above_clk_min,
  output logic             switch_one,
  output logic             switch_two,
  output logic             switch_three,
  output logic             backup_mode,
  output logic             comp_update_hold,
  output logic             host_io_ignore,
  output logic             out_pins_oe_n,
  output logic             calendar_run,
  output logic      [3:0]  event_sources
);
  generate
    // the oscillator synchroniser leaves reset low, so a very short stop count would flag a false stop
    if (OSC_CYC < 4 || SMP_CYC < 2 || BAT_CYC < 4) begin : g_bad
      $error("timing counts too small");
    end
  endgenerate

  localparam logic [31:0] OSC_LIM  = 32'(OSC_CYC);
  localparam logic [31:0] SMP_LAST = 32'(SMP_CYC - 1);
  localparam logic [31:0] BAT_LAST = 32'(BAT_CYC - 1);
  localparam logic [31:0] BAT_HALF = 32'(BAT_CYC / 2 - 1);

  logic [supply_pkg::N_SYNC-1:0] sync_q;
  logic osc_s, main_low_s, main_rise_s, bat_low_s, bat_rise_s;
  logic vout_low_s, main_gt_bat_s, bat_clk_s;

  // input synchroniser
  sync_bits #(.WIDTH(supply_pkg::N_SYNC)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({osc_active, main_below_drop, main_above_rise, battery_below_drop,
               battery_above_rise, vout_below_comp, main_above_battery,
               battery_above_clk_min}),
    .q       (sync_q)
  );
  assign {osc_s, main_low_s, main_rise_s, bat_low_s, bat_rise_s,
          vout_low_s, main_gt_bat_s, bat_clk_s} = sync_q;

  supply_pkg::power_mode_t mode_ff;
  supply_pkg::power_mode_t nxt_mode;
  logic [31:0] osc_cnt_ff;
  logic [31:0] smp_cnt_ff;
  logic [31:0] bat_cnt_ff;
  logic        osc_flag_ff, inv_flag_ff, por_flag_ff, comp_flag_ff;
  logic        main_flag_ff, bat_flag_ff, bat_low_seen_ff, charge_on_ff;
  logic        auto_en_ff, chg_en_ff, det_bk_ff, det_en_ff;
  logic [1:0]  samp_ff, sel_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic        osc_stopped, smp_tick, bat_tick, bat_half, bat_check, in_normal;
  logic        addr_phase, wr_ok, wr_status, wr_supply, wr_config;
  logic [31:0] rd_mux;

  assign in_normal   = (mode_ff == supply_pkg::mode_normal);
  // stop duration reached
  assign osc_stopped = (osc_cnt_ff == OSC_LIM);
  assign smp_tick    = (smp_cnt_ff == SMP_LAST);
  assign bat_tick    = (bat_cnt_ff == BAT_LAST);
  assign bat_half    = (bat_cnt_ff == BAT_HALF);
  // battery check gating
  assign bat_check   = bat_tick && det_en_ff && (in_normal || det_bk_ff);

  // ---------------- bus slave ----------------
  assign addr_phase = hsel && htrans[1] && hready;
  // host writes dropped in Backup
  assign wr_ok     = wr_pend_ff && in_normal;
  assign wr_status = wr_ok && (wr_addr_ff == supply_pkg::REG_STATUS);
  assign wr_supply = wr_ok && (wr_addr_ff == supply_pkg::REG_SUPPLY);
  assign wr_config = wr_ok && (wr_addr_ff == supply_pkg::REG_CONFIG);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000) begin
      case (haddr[7:0])
        supply_pkg::REG_STATUS:  rd_mux[3:0] = {comp_flag_ff, por_flag_ff, inv_flag_ff,
                                                osc_flag_ff};
        supply_pkg::REG_SUPPLY:  rd_mux[1:0] = {bat_flag_ff, main_flag_ff};
        supply_pkg::REG_CONFIG:  rd_mux[7:0] = {sel_ff, samp_ff, det_en_ff, det_bk_ff,
                                                chg_en_ff, auto_en_ff};
        supply_pkg::REG_MONITOR: rd_mux[8:0] = {charge_on_ff, switch_three, switch_two,
                                                switch_one, backup_mode, vout_low_s,
                                                bat_low_s, main_low_s, osc_s};
        default:                 rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_pend_ff <= addr_phase && hwrite && (hsize == supply_pkg::SIZE_WORD)
                    && (haddr[31:8] == 24'h00_0000);
      wr_addr_ff <= haddr[7:0];
      hrdata     <= (addr_phase && !hwrite) ? rd_mux : 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  // ---------------- configuration ----------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // power-on defaults
      auto_en_ff <= 1'b0;
      chg_en_ff  <= 1'b0;
      det_bk_ff  <= 1'b0;
      det_en_ff  <= 1'b0;
      samp_ff    <= 2'h0;
      sel_ff     <= supply_pkg::SEL_RESET;
    end else if (wr_config) begin
      auto_en_ff <= hwdata[supply_pkg::B_AUTO];
      chg_en_ff  <= hwdata[supply_pkg::B_CHG];
      det_bk_ff  <= hwdata[supply_pkg::B_DBK];
      det_en_ff  <= hwdata[supply_pkg::B_DEN];
      samp_ff    <= hwdata[supply_pkg::B_SAMP +: 2];
      sel_ff     <= hwdata[supply_pkg::B_SEL +: 2];
    end
  end

  // ---------------- timers ----------------
  // counter saturates so a long stop still reads as stopped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_cnt_ff <= 32'h0000_0000;
    end else if (osc_s) begin
      osc_cnt_ff <= 32'h0000_0000;
    end else if (!osc_stopped) begin
      osc_cnt_ff <= osc_cnt_ff + 32'h0000_0001;
    end
  end

  // backup sampling period
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      smp_cnt_ff <= 32'h0000_0000;
    end else if (in_normal || smp_tick) begin
      smp_cnt_ff <= 32'h0000_0000;
    end else begin
      smp_cnt_ff <= smp_cnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bat_cnt_ff <= 32'h0000_0000;
    end else if (!auto_en_ff || bat_tick) begin
      bat_cnt_ff <= 32'h0000_0000;
    end else begin
      bat_cnt_ff <= bat_cnt_ff + 32'h0000_0001;
    end
  end

  // ---------------- status flags ----------------
  // set always wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_flag_ff  <= 1'b0;
      por_flag_ff  <= 1'b1;
      inv_flag_ff  <= 1'b1;
      comp_flag_ff <= 1'b0;
    end else begin
      // sticky oscillator stop
      if (osc_stopped) begin
        osc_flag_ff <= 1'b1;
      end else if (wr_status && !hwdata[supply_pkg::B_OSC]) begin
        osc_flag_ff <= 1'b0;
      end
      if (wr_status && !hwdata[supply_pkg::B_POR]) begin
        por_flag_ff <= 1'b0;
      end
      // invalid time follows
      if (osc_stopped || por_flag_ff) begin
        inv_flag_ff <= 1'b1;
      end else if (wr_status && !hwdata[supply_pkg::B_INV]) begin
        inv_flag_ff <= 1'b0;
      end
      // compensation stop
      if (vout_low_s) begin
        comp_flag_ff <= 1'b1;
      end else if (wr_status && !hwdata[supply_pkg::B_COMP]) begin
        comp_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      main_flag_ff    <= 1'b0;
      bat_flag_ff     <= 1'b0;
      bat_low_seen_ff <= 1'b0;
    end else begin
      // main drop, cleared only after rise
      if (auto_en_ff && main_low_s) begin
        main_flag_ff <= 1'b1;
      end else if (wr_supply && !hwdata[supply_pkg::B_MAIN] && main_rise_s) begin
        main_flag_ff <= 1'b0;
      end
      // two consecutive low checks
      if (!auto_en_ff) begin
        bat_low_seen_ff <= 1'b0;
      end else if (bat_check) begin
        bat_low_seen_ff <= bat_low_s;
      end
      if (bat_check && bat_low_s && bat_low_seen_ff) begin
        bat_flag_ff <= 1'b1;
      end else if (wr_supply && !hwdata[supply_pkg::B_BAT] && bat_rise_s) begin
        bat_flag_ff <= 1'b0;
      end
    end
  end

  // flags out as event sources
  assign event_sources = {comp_flag_ff, bat_flag_ff, main_flag_ff, osc_flag_ff};

  // ---------------- power mode ----------------
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      // drop enters Backup
      supply_pkg::mode_normal: if (auto_en_ff && main_low_s) begin
        nxt_mode = supply_pkg::mode_backup;
      end
      // recovery returns to Normal
      supply_pkg::mode_backup: if (!auto_en_ff || (smp_tick && main_rise_s)) begin
        nxt_mode = supply_pkg::mode_normal;
      end
      default: nxt_mode = supply_pkg::mode_normal;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= supply_pkg::mode_normal;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // charge decision twice per period
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      charge_on_ff <= 1'b0;
    end else if (!(auto_en_ff && chg_en_ff && in_normal)) begin
      charge_on_ff <= 1'b0;
    end else if (bat_tick || bat_half) begin
      charge_on_ff <= main_gt_bat_s;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      switch_one   <= 1'b0;
      switch_two   <= 1'b0;
      switch_three <= 1'b1;
    end else if (auto_en_ff) begin
      // automatic control, switch one open in Backup
      switch_one   <= in_normal;
      switch_two   <= !in_normal || charge_on_ff;
      switch_three <= in_normal && charge_on_ff;
    end else begin
      switch_one   <= sel_ff[1];
      switch_two   <= 1'b0;
      switch_three <= sel_ff[0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      backup_mode      <= 1'b0;
      host_io_ignore   <= 1'b0;
      out_pins_oe_n    <= 1'b0;
      comp_update_hold <= 1'b0;
      calendar_run     <= 1'b1;
    end else begin
      backup_mode      <= !in_normal;
      // pins float in Backup
      host_io_ignore   <= !in_normal;
      out_pins_oe_n    <= !in_normal;
      // hold last correction
      comp_update_hold <= vout_low_s;
      // timekeeping in Backup
      calendar_run     <= in_normal || bat_clk_s;
    end
  end

  // ---------------- checks ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_osc_flag_set: assert property (osc_stopped |=> osc_flag_ff)
    else $error("oscillator flag not set");
  a_osc_set_cause: assert property ($rose(osc_flag_ff) |-> $past(osc_cnt_ff) == OSC_LIM)
    else $error("oscillator flag set early");
  a_invalid_follows: assert property ($rose(osc_flag_ff) |-> inv_flag_ff)
    else $error("invalid flag missed");
  a_main_drop_gate: assert property ($rose(main_flag_ff) |-> $past(auto_en_ff))
    else $error("main flag without enable");
  a_main_clear_guard: assert property ($fell(main_flag_ff) |-> $past(main_rise_s))
    else $error("main flag cleared too early");
  a_battery_twice: assert property ($rose(bat_flag_ff) |-> $past(bat_low_seen_ff))
    else $error("battery flag after one check");
  a_comp_hold: assert property (vout_low_s |=> comp_flag_ff && comp_update_hold)
    else $error("compensation stop missed");
  a_enter_backup: assert property (in_normal && auto_en_ff && main_low_s
      |=> !in_normal ##1 (!switch_one && backup_mode))
    else $error("backup entry wrong");
  a_backup_pins: assert property (backup_mode |-> out_pins_oe_n && host_io_ignore)
    else $error("pins active in backup");
  a_return_sampled: assert property ($fell(backup_mode) |-> $past(smp_tick, 2)
      || !$past(auto_en_ff, 2))
    else $error("return without sample");
  a_manual_select: assert property (!auto_en_ff |=> switch_one == $past(sel_ff[1])
      && !switch_two)
    else $error("manual switches wrong");

  c_enter_backup: cover property ($rose(backup_mode));
  c_leave_backup: cover property ($fell(backup_mode));
  c_battery_flag: cover property ($rose(bat_flag_ff));
  c_osc_flag: cover property ($rose(osc_flag_ff));
endmodule

// ===== hdl/supply_pkg.sv
package supply_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned OSC_STOP_MS     = 10;
  localparam int unsigned OSC_STOP_CYC    = (CLK_HZ / 1000) * OSC_STOP_MS;
  localparam real         MAIN_SAMPLE_MS  = 31.25;
  localparam int unsigned MAIN_SAMPLE_CYC = $rtoi(MAIN_SAMPLE_MS * CLK_HZ / 1000.0);
  localparam int unsigned BAT_CHECK_S     = 3;
  localparam int unsigned BAT_CHECK_CYC   = CLK_HZ * BAT_CHECK_S;

  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_SUPPLY  = 8'h04;
  localparam logic [7:0] REG_CONFIG  = 8'h08;
  localparam logic [7:0] REG_MONITOR = 8'h0C;
  localparam logic [2:0] SIZE_WORD   = 3'h2;

  // status register bits
  localparam int B_OSC  = 0;
  localparam int B_INV  = 1;
  localparam int B_POR  = 2;
  localparam int B_COMP = 3;
  // supply register bits
  localparam int B_MAIN = 0;
  localparam int B_BAT  = 1;
  // config register bits
  localparam int B_AUTO = 0;
  localparam int B_CHG  = 1;
  localparam int B_DBK  = 2;
  localparam int B_DEN  = 3;
  localparam int B_SAMP = 4;
  localparam int B_SEL  = 6;

  localparam logic [1:0] SEL_RESET = 2'h1;
  localparam int         N_SYNC    = 8;

  typedef enum logic {mode_normal, mode_backup} power_mode_t;
endpackage

// ===== hdl/sync_bits.sv
`timescale 1ns/1ps
module sync_bits #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// ===== verification/host_model.sv
`timescale 1ns/1ps
// bus master standing in for the host processor
module host_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel   = 1'h0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // sampled on the low phase so the edge's own updates never race the capture
  task automatic phase(output logic [31:0] d, output logic ok);
    logic r;
    ok = 1'b0;
    for (int i = 0; i < 32 && !ok; i++) begin
      @(negedge clk);
      r = hready;
      d = hrdata;
      @(posedge clk);
      ok = (r === 1'b1);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    logic        ok1;
    logic [31:0] dd;
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= supply_pkg::SIZE_WORD;
    haddr  <= {24'h00_0000, a};
    phase(dd, ok1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    phase(rd, ok);
    ok = ok & ok1;
  endtask
endmodule

// ===== verification/supply_monitor_power_switch_bench.sv
`timescale 1ns/1ps
module supply_monitor_power_switch_bench;
  typedef struct packed {logic [7:0] cfg; logic [2:0] sw;} row_t;
  logic        clk, reset_n, hsel, hwrite, hready, hresp, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        osc_active, main_below_drop, main_above_rise, battery_below_drop;
  logic        battery_above_rise, vout_below_comp, main_above_battery;
  logic        battery_above_clk_min, switch_one, switch_two, switch_three;
  logic        backup_mode, comp_update_hold, host_io_ignore, out_pins_oe_n;
  logic        calendar_run;
  logic [3:0]  event_sources;
  logic [8:0]  obs;
  int          err_total, n_tests;
  // switch pattern is {three, two, one}
  row_t rows [5] = '{'{8'h00, 3'h0}, '{8'h40, 3'h4}, '{8'h80, 3'h1},
                     '{8'hC0, 3'h5}, '{8'h41, 3'h1}};

  assign hready = hreadyout;
  assign obs = {comp_update_hold, switch_three, switch_two, switch_one, backup_mode,
                event_sources};

  supply_monitor_power_switch #(.OSC_CYC(20), .SMP_CYC(16), .BAT_CYC(64))
  i_supply_monitor_power_switch (.clk(clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .osc_active(osc_active), .main_below_drop(main_below_drop),
    .main_above_rise(main_above_rise), .battery_below_drop(battery_below_drop),
    .battery_above_rise(battery_above_rise), .vout_below_comp(vout_below_comp),
    .main_above_battery(main_above_battery), .battery_above_clk_min(battery_above_clk_min),
    .switch_one(switch_one), .switch_two(switch_two), .switch_three(switch_three),
    .backup_mode(backup_mode), .comp_update_hold(comp_update_hold),
    .host_io_ignore(host_io_ignore), .out_pins_oe_n(out_pins_oe_n),
    .calendar_run(calendar_run), .event_sources(event_sources));

  host_model i_host_model (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  task automatic give_verdict();
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        ok;
    i_host_model.xfer(1'b1, a, d, x, ok);
    if (!ok) begin
      err_total++;
      give_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ok;
    i_host_model.xfer(1'b0, a, 32'h0000_0000, d, ok);
    if (!ok) begin
      err_total++;
      give_verdict();
    end
    @(negedge clk);
  endtask

  // waits on the low phase for one observed bit; running out ends the run
  task automatic wait_obs(input int b, input logic val, input int lim);
    int i;
    for (i = 0; i < lim && obs[b] !== val; i++) begin
      @(negedge clk);
    end
    if (obs[b] !== val) begin
      err_total++;
      give_verdict();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial begin
    err_total = 0;
    n_tests = 0;
    reset_n = 1'b0;
    osc_active = 1'b1;
    main_below_drop = 1'b0;
    main_above_rise = 1'b1;
    battery_below_drop = 1'b0;
    battery_above_rise = 1'b1;
    vout_below_comp = 1'b0;
    main_above_battery = 1'b0;
    battery_above_clk_min = 1'b1;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(supply_pkg::REG_STATUS, v);
    check(v, 32'h0000_0006);
    rd(supply_pkg::REG_CONFIG, v);
    check({24'h00_0000, v[7:0]}, 32'h0000_0040);
    rd(supply_pkg::REG_MONITOR, v);
    check(v, 32'h0000_0081);
    check({23'h00_0000, obs}, 32'h0000_0080);
    check({28'h000_0000, hresp, out_pins_oe_n, host_io_ignore, calendar_run}, 32'h1);
    wr(supply_pkg::REG_STATUS, 32'h0000_0000);
    wr(supply_pkg::REG_STATUS, 32'h0000_0000);
    rd(supply_pkg::REG_STATUS, v);
    check(v, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(supply_pkg::REG_CONFIG, {24'h00_0000, rows[i].cfg});
      rd(supply_pkg::REG_CONFIG, v);
      check({24'h00_0000, v[7:0]}, {24'h00_0000, rows[i].cfg});
      check({29'h0, switch_three, switch_two, switch_one}, {29'h0, rows[i].sw});
    end
    rd(8'h20, v);
    check(v, 32'h0000_0000);
    @(posedge clk);
    osc_active <= 1'b0;
    repeat (15) @(negedge clk);
    check({31'h0, event_sources[0]}, 32'h0);
    wait_obs(0, 1'b1, 30);
    rd(supply_pkg::REG_STATUS, v);
    check(v, 32'h0000_0003);
    wr(supply_pkg::REG_STATUS, 32'h0000_0000);
    rd(supply_pkg::REG_STATUS, v);
    check(v, 32'h0000_0003);
    @(posedge clk);
    osc_active <= 1'b1;
    repeat (6) @(posedge clk);
    rd(supply_pkg::REG_STATUS, v);
    check(v, 32'h0000_0003);
    wr(supply_pkg::REG_STATUS, 32'h0000_0000);
    rd(supply_pkg::REG_STATUS, v);
    check(v, 32'h0000_0000);
    wr(supply_pkg::REG_CONFIG, 32'h0000_0040);
    @(posedge clk);
    main_below_drop <= 1'b1;
    repeat (10) @(negedge clk);
    check({28'h0, obs[4:1]}, 32'h0);
    @(posedge clk);
    main_below_drop <= 1'b0;
    wr(supply_pkg::REG_CONFIG, 32'h0000_0040);
    wr(supply_pkg::REG_CONFIG, 32'h0000_0041);
    wr(supply_pkg::REG_CONFIG, 32'h0000_0045);
    wr(supply_pkg::REG_CONFIG, 32'h0000_004D);
    wr(supply_pkg::REG_CONFIG, 32'h0000_005D);
    @(posedge clk);
    battery_below_drop <= 1'b1;
    battery_above_rise <= 1'b0;
    repeat (60) @(negedge clk);
    check({31'h0, event_sources[2]}, 32'h0);
    wait_obs(2, 1'b1, 140);
    check({31'h0, backup_mode}, 32'h0);
    wr(supply_pkg::REG_SUPPLY, 32'h0000_0000);
    rd(supply_pkg::REG_SUPPLY, v);
    check(v, 32'h0000_0002);
    @(posedge clk);
    battery_below_drop <= 1'b0;
    battery_above_rise <= 1'b1;
    wr(supply_pkg::REG_SUPPLY, 32'h0000_0000);
    rd(supply_pkg::REG_SUPPLY, v);
    check(v, 32'h0000_0000);
    @(posedge clk);
    vout_below_comp <= 1'b1;
    wait_obs(8, 1'b1, 8);
    wait_obs(3, 1'b1, 8);
    check({28'h0, event_sources}, 32'h8);
    wr(supply_pkg::REG_STATUS, 32'h0000_0000);
    rd(supply_pkg::REG_STATUS, v);
    check(v, 32'h0000_0008);
    @(posedge clk);
    vout_below_comp <= 1'b0;
    repeat (4) @(negedge clk);
    check({31'h0, comp_update_hold}, 32'h0);
    wr(supply_pkg::REG_STATUS, 32'h0000_0000);
    rd(supply_pkg::REG_STATUS, v);
    check(v, 32'h0000_0000);
    @(posedge clk);
    main_below_drop <= 1'b1;
    main_above_rise <= 1'b0;
    wait_obs(4, 1'b1, 8);
    repeat (2) @(negedge clk);
    check({23'h0, obs}, 32'h0000_0052);
    check({29'h0, out_pins_oe_n, host_io_ignore, calendar_run}, 32'h7);
    @(posedge clk);
    battery_above_clk_min <= 1'b0;
    repeat (4) @(negedge clk);
    check({31'h0, calendar_run}, 32'h0);
    @(posedge clk);
    battery_above_clk_min <= 1'b1;
    // write while in backup must be dropped
    wr(supply_pkg::REG_CONFIG, 32'h0000_0040);
    @(posedge clk);
    main_below_drop <= 1'b0;
    repeat (40) @(negedge clk);
    check({31'h0, backup_mode}, 32'h1);
    @(posedge clk);
    main_above_rise <= 1'b1;
    wait_obs(4, 1'b0, 40);
    repeat (2) @(negedge clk);
    check({29'h0, obs[6:4]}, 32'h2);
    rd(supply_pkg::REG_CONFIG, v);
    check({24'h00_0000, v[7:0]}, 32'h0000_005D);
    @(posedge clk);
    main_above_rise <= 1'b0;
    wr(supply_pkg::REG_SUPPLY, 32'h0000_0000);
    rd(supply_pkg::REG_SUPPLY, v);
    check(v, 32'h0000_0001);
    @(posedge clk);
    main_above_rise <= 1'b1;
    wr(supply_pkg::REG_SUPPLY, 32'h0000_0000);
    rd(supply_pkg::REG_SUPPLY, v);
    check(v, 32'h0000_0000);
    wr(supply_pkg::REG_CONFIG, 32'h0000_005F);
    @(posedge clk);
    main_above_battery <= 1'b1;
    wait_obs(6, 1'b1, 150);
    repeat (2) @(negedge clk);
    check({29'h0, obs[7:5]}, 32'h7);
    // mid-run reset must bring back the power-on state
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(negedge clk);
    check({23'h0, obs}, 32'h0000_0080);
    @(posedge clk);
    reset_n <= 1'b1;
    rd(supply_pkg::REG_STATUS, v);
    check(v, 32'h0000_0006);
    rd(supply_pkg::REG_CONFIG, v);
    check({24'h00_0000, v[7:0]}, 32'h0000_0040);
    give_verdict();
  end
endmodule
